// ===== core/cpss_pkg.sv
package cpss_pkg;
  // sfr addresses
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] SYS_SET_ADDR = 8'hee;
  // power control fields
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_HALT_BIT = 1;
  localparam int PC_FLAG_LSB = 2;
  localparam int PC_FLAG_W = 6;
  localparam logic [5:0] PC_FLAG_RST = 6'h00;
  // system settings fields
  localparam int SS_HEAT_ENA_BIT = 0;
  localparam int SS_HEAT_HIPOW_BIT = 1;
  localparam int SS_LCM_DIS_BIT = 2;
  localparam int SS_DECRYPT_BIT = 3;
  localparam int SS_ANTIC_BIT = 4;
  localparam logic [7:0] SS_WR_MASK = 8'h1f;
  localparam logic [4:0] SS_RST = 5'h00;
  // heater graceful shutdown, in ns and cycles of the 100 ns clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int HEAT_SHDN_NS = 10000;
  localparam int HEAT_SHDN_CYC = HEAT_SHDN_NS / CLK_PERIOD_NS;
  localparam logic [7:0] HEAT_SHDN_CNT = 8'(HEAT_SHDN_CYC);

  typedef enum logic [1:0] {HT_OFF, HT_ON, HT_SHDN} cpss_heat_t;

  typedef enum logic [1:0] {CPU_RUN, CPU_IDLE, CPU_HALT} cpss_cpu_t;

  // sfr bus request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic sw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpss_sfr_req_t;

  typedef struct packed {
    logic [5:0] user_flag_field;
    logic [4:0] sys_set;
    cpss_cpu_t cpu;
    cpss_heat_t heat;
    logic [7:0] shdn_cnt;
    logic [7:0] rdata;
    logic ram_wait;
    logic ram_busy;
    logic heat_out;
  } cpss_state_t;
endpackage : cpss_pkg

// ===== core/cpss_regs.sv
`timescale 1ns/100ps
// Contract
// - power control resets to zero; only software access, never debug port
// - idle bit set stops execution; peripherals keep clocks
// - idle ends on any interrupt or any reset
// - halt bit set halts execution; peripherals and system clock keep running
// - halt ends only on reset, not on interrupts
// - idle and halt bits always read zero
// - power control bits 7:2 are six user flags, reset zero
// - settings bits 7:5 read zero, writes ignored; others reset zero
// - settings bit 4 enables ram read anticipation
// - without anticipation every shared ram read waits one extra cycle
// - settings bit 3 selects decrypt table, zero selects encrypt
// - settings bit 2 gates off the modulator clock
// - settings bit 1 selects heater high power mode
// - settings bit 0 applies current heating power to heater
// - heater enable falling keeps controller running for graceful shutdown
// - system reset returns both registers to reset values
module cpss_regs (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // sfr bus
  input wire cpss_pkg::cpss_sfr_req_t sfr_i,
  output logic [7:0] sfr_rdata_o,
  // cpu core
  input wire logic irq_i,
  input wire logic ram_rd_i,
  output logic cpu_stall_o,
  output logic ram_wait_o,
  // peripheral controls
  output logic antic_en_o,
  output logic sbox_decrypt_o,
  output logic lcm_clk_gate_o,
  output logic heat_hipow_o,
  output logic heat_apply_o,
  output logic heat_shdn_o
);
  cpss_pkg::cpss_state_t st_r;
  cpss_pkg::cpss_state_t st_nxt;
  logic pc_wr;
  logic ss_wr;
  logic [7:0] ss_wd;

  always_comb begin
    st_nxt = st_r;
    // software only: debug accesses carry sw low
    // software-only access for power control; settings writes ignore sw
    pc_wr = sfr_i.wr && sfr_i.sw && (sfr_i.addr == cpss_pkg::PWR_CTRL_ADDR);
    ss_wr = sfr_i.wr && (sfr_i.addr == cpss_pkg::SYS_SET_ADDR);
    ss_wd = sfr_i.wdata & cpss_pkg::SS_WR_MASK;
    if (pc_wr) begin
      st_nxt.user_flag_field = sfr_i.wdata[cpss_pkg::PC_FLAG_LSB +: cpss_pkg::PC_FLAG_W];
    end
    if (ss_wr) begin
      st_nxt.sys_set = ss_wd[4:0];
    end
    // cpu power state
    case (st_r.cpu)
      cpss_pkg::CPU_RUN: begin
        if (pc_wr && sfr_i.wdata[cpss_pkg::PC_HALT_BIT]) begin
          st_nxt.cpu = cpss_pkg::CPU_HALT;
        end else if (pc_wr && sfr_i.wdata[cpss_pkg::PC_IDLE_BIT]) begin
          st_nxt.cpu = cpss_pkg::CPU_IDLE;
        end
      end
      cpss_pkg::CPU_IDLE: begin
        if (irq_i) begin
          st_nxt.cpu = cpss_pkg::CPU_RUN;
        end
      end
      cpss_pkg::CPU_HALT: st_nxt.cpu = cpss_pkg::CPU_HALT;
      default: st_nxt.cpu = cpss_pkg::CPU_RUN;
    endcase
    // one wait cycle per read when anticipation is off
    st_nxt.ram_wait = 1'b0;
    st_nxt.ram_busy = 1'b0;
    if (ram_rd_i && !st_r.sys_set[cpss_pkg::SS_ANTIC_BIT] && !st_r.ram_busy) begin
      st_nxt.ram_wait = 1'b1;
      st_nxt.ram_busy = 1'b1;
    end
    // heater controller, driven by the committed enable bit
    case (st_r.heat)
      cpss_pkg::HT_OFF: begin
        if (st_r.sys_set[cpss_pkg::SS_HEAT_ENA_BIT]) begin
          st_nxt.heat = cpss_pkg::HT_ON;
        end
      end
      cpss_pkg::HT_ON: begin
        if (!st_r.sys_set[cpss_pkg::SS_HEAT_ENA_BIT]) begin
          st_nxt.heat = cpss_pkg::HT_SHDN;
          st_nxt.shdn_cnt = cpss_pkg::HEAT_SHDN_CNT;
        end
      end
      cpss_pkg::HT_SHDN: begin
        if (st_r.sys_set[cpss_pkg::SS_HEAT_ENA_BIT]) begin
          st_nxt.heat = cpss_pkg::HT_ON;
        end else if (st_r.shdn_cnt <= 8'h01) begin
          st_nxt.heat = cpss_pkg::HT_OFF;
          st_nxt.shdn_cnt = 8'h00;
        end else begin
          st_nxt.shdn_cnt = st_r.shdn_cnt - 8'h01;
        end
      end
      default: st_nxt.heat = cpss_pkg::HT_OFF;
    endcase
    st_nxt.heat_out = (st_nxt.heat == cpss_pkg::HT_ON);
    // read data, registered
    st_nxt.rdata = 8'h00;
    if (sfr_i.rd && sfr_i.sw && sfr_i.addr == cpss_pkg::PWR_CTRL_ADDR) begin
      st_nxt.rdata = {st_r.user_flag_field, 2'b00};
    end else if (sfr_i.rd && sfr_i.addr == cpss_pkg::SYS_SET_ADDR) begin
      st_nxt.rdata = {3'b000, st_r.sys_set};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_r.user_flag_field <= cpss_pkg::PC_FLAG_RST;
      st_r.sys_set <= cpss_pkg::SS_RST;
      st_r.cpu <= cpss_pkg::CPU_RUN;
      st_r.heat <= cpss_pkg::HT_OFF;
      st_r.shdn_cnt <= 8'h00;
      st_r.rdata <= 8'h00;
      st_r.ram_wait <= 1'b0;
      st_r.ram_busy <= 1'b0;
      st_r.heat_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_o = st_r.rdata;
  assign cpu_stall_o = (st_r.cpu != cpss_pkg::CPU_RUN);
  assign ram_wait_o = st_r.ram_wait;
  assign antic_en_o = st_r.sys_set[cpss_pkg::SS_ANTIC_BIT];
  assign sbox_decrypt_o = st_r.sys_set[cpss_pkg::SS_DECRYPT_BIT];
  assign lcm_clk_gate_o = st_r.sys_set[cpss_pkg::SS_LCM_DIS_BIT];
  assign heat_hipow_o = st_r.sys_set[cpss_pkg::SS_HEAT_HIPOW_BIT];
  assign heat_apply_o = st_r.heat_out;
  assign heat_shdn_o = (st_r.heat == cpss_pkg::HT_SHDN);
endmodule : cpss_regs

// ===== testbench/cpss_asserts.sv
`timescale 1ns/100ps
module cpss_asserts (
  input wire logic mclk_i, srst_i, irq_i, ram_rd_i,
  input wire cpss_pkg::cpss_sfr_req_t sfr_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic cpu_stall_o, ram_wait_o, antic_en_o, sbox_decrypt_o,
  input wire logic lcm_clk_gate_o, heat_hipow_o, heat_apply_o, heat_shdn_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence pc_rd;
    sfr_i.rd && sfr_i.addr == cpss_pkg::PWR_CTRL_ADDR;
  endsequence
  sequence ss_wr;
    sfr_i.wr && sfr_i.addr == cpss_pkg::SYS_SET_ADDR;
  endsequence
  sequence halt_wr;
    sfr_i.wr && sfr_i.sw && sfr_i.addr == cpss_pkg::PWR_CTRL_ADDR && sfr_i.wdata[1];
  endsequence
  a_rdata_quiet: assert property (!sfr_i.rd |=> sfr_rdata_o == 8'h00)
    else $error("read data not zero");
  a_req_bits_zero: assert property (pc_rd |=> sfr_rdata_o[1:0] == 2'h0)
    else $error("idle or halt bit read back");
  a_debug_blocked: assert property (pc_rd and !sfr_i.sw |=> sfr_rdata_o == 8'h00)
    else $error("debug read of power control");
  a_reserved_zero: assert property (sfr_i.rd && sfr_i.addr == cpss_pkg::SYS_SET_ADDR
    |=> sfr_rdata_o[7:5] == 3'h0)
    else $error("reserved settings bits set");
  a_ctrl_map: assert property (ss_wr |=> {antic_en_o, sbox_decrypt_o, lcm_clk_gate_o,
    heat_hipow_o} == $past(sfr_i.wdata[4:1]))
    else $error("settings outputs wrong");
  a_halt_hold: assert property (halt_wr and !cpu_stall_o |=> cpu_stall_o [*8])
    else $error("halt released early");
  a_ram_wait: assert property (ram_rd_i && !antic_en_o && !ram_wait_o |=> ram_wait_o)
    else $error("no wait cycle");
  a_antic_nowait: assert property (ram_rd_i && antic_en_o |=> !ram_wait_o)
    else $error("wait with anticipation");
  a_shdn_graceful: assert property ($fell(heat_apply_o) && !$past(srst_i)
    |-> (heat_shdn_o || heat_apply_o) [*8])
    else $error("heater cut off at once");
  a_shdn_ends: assert property ($rose(heat_shdn_o) |-> ##[1:120] !heat_shdn_o)
    else $error("shutdown never ends");
endmodule : cpss_asserts

// ===== testbench/cpss_cpu_model.sv
`timescale 1ns/100ps
module cpss_cpu_model (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output cpss_pkg::cpss_sfr_req_t sfr_o,
  output logic irq_o,
  output logic ram_rd_o
);
  initial {sfr_o, irq_o, ram_rd_o} = '0;
  task automatic xfer(input logic w, s, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge mclk_i);
    sfr_o = '{w, !w, s, a, d};
    @(negedge mclk_i);
    q = rdata_i;
    // released lines show no stale value
    sfr_o = '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask : xfer
  task ram;
    @(negedge mclk_i);
    ram_rd_o = 1'b1;
    @(negedge mclk_i);
    ram_rd_o = 1'b0;
  endtask : ram
endmodule : cpss_cpu_model

// ===== testbench/cpss_regs_test.sv
`timescale 1ns/100ps
module cpss_regs_test;
  logic mclk_i = 0, srst_i = 1;
  cpss_pkg::cpss_sfr_req_t sfr;
  logic [7:0] rdata, q;
  logic irq, ram_rd, stall, rwait, antic, dec, lcm, hipow, apply, shdn;
  int err_count = 0, checked = 0;
  always #50 mclk_i = ~mclk_i;
  cpss_cpu_model cpss_cpu_model_i (.mclk_i(mclk_i), .rdata_i(rdata), .sfr_o(sfr),
    .irq_o(irq), .ram_rd_o(ram_rd));
  cpss_regs cpss_regs_i (.mclk_i(mclk_i), .srst_i(srst_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
    .irq_i(irq), .ram_rd_i(ram_rd), .cpu_stall_o(stall), .ram_wait_o(rwait),
    .antic_en_o(antic), .sbox_decrypt_o(dec), .lcm_clk_gate_o(lcm),
    .heat_hipow_o(hipow), .heat_apply_o(apply), .heat_shdn_o(shdn));
  task chk(input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task rd(input logic [7:0] a, e, input logic s = 1);
    cpss_cpu_model_i.xfer(1'b0, s, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task wr(input logic [7:0] a, d, input logic s = 1);
    cpss_cpu_model_i.xfer(1'b1, s, a, d, q);
  endtask : wr
  task cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc
  task results;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    cyc(5);
    srst_i = 0;
    rd(8'h87, 8'h00);
    rd(8'hee, 8'h00);
    rd(8'h55, 8'h00);
    chk({stall, rwait, antic, dec, lcm, hipow, apply, shdn}, 8'h00);
    $display("reset test done");
    wr(8'h87, 8'hfc);
    rd(8'h87, 8'hfc);
    wr(8'h87, 8'h00, 0);
    rd(8'h87, 8'h00, 0);
    rd(8'h87, 8'hfc);
    $display("flag test done");
    wr(8'hee, 8'hff);
    rd(8'hee, 8'h1f);
    chk({2'h0, antic, dec, lcm, hipow, apply, shdn}, 8'h3e);
    wr(8'hee, 8'h00);
    cyc(1);
    chk({6'h00, apply, shdn}, 8'h01);
    wr(8'hee, 8'h01);
    cyc(1);
    chk({6'h00, apply, shdn}, 8'h02);
    wr(8'hee, 8'h00);
    cyc(105);
    chk({6'h00, apply, shdn}, 8'h00);
    $display("settings test done");
    cpss_cpu_model_i.ram();
    chk({7'h00, rwait}, 8'h01);
    wr(8'hee, 8'h10);
    cpss_cpu_model_i.ram();
    chk({7'h00, rwait}, 8'h00);
    wr(8'hee, 8'h0a);
    chk({4'h0, antic, dec, lcm, hipow}, 8'h05);
    $display("ram test done");
    wr(8'h87, 8'hfd);
    chk({7'h00, stall}, 8'h01);
    cpss_cpu_model_i.irq_o = 1'b1;
    cyc(3);
    chk({7'h00, stall}, 8'h00);
    cpss_cpu_model_i.irq_o = 1'b0;
    // both mode bits: halt must win over idle
    wr(8'h87, 8'hff);
    rd(8'h87, 8'hfc);
    cpss_cpu_model_i.irq_o = 1'b1;
    cyc(5);
    chk({7'h00, stall}, 8'h01);
    cpss_cpu_model_i.irq_o = 1'b0;
    srst_i = 1;
    cyc(2);
    srst_i = 0;
    chk({7'h00, stall}, 8'h00);
    rd(8'h87, 8'h00);
    rd(8'hee, 8'h00);
    $display("power test done");
    results();
  end
endmodule : cpss_regs_test
bind cpss_regs cpss_asserts cpss_asserts_i (.*);
